/* File: pkg/lpbm_pkg.sv */
// Purpose: Constants for the low-power and boot-mode controller.
// Assumes: 50 MHz MCLK_I, APB register access.
// Notes:   Offsets are byte addresses.
package lpbm_pkg;
   // Register map
   localparam logic [7:0] MISC_CTRL_OFF   = 8'h0c;
   localparam logic [7:0] MODE_STAT_OFF   = 8'h10;
   localparam logic [7:0] PWR_CMD_OFF     = 8'h14;
   localparam logic [7:0] SELFTEST_OFF    = 8'h18;
   localparam logic [7:0] MISC_CTRL_RST   = 8'h10;
   // Field positions in misc_control
   localparam int LOW_VOLTAGE_RESET_ENABLE_BIT = 3;
   localparam int SM_BIT   = 2;
   // Command codes in pwr_cmd
   localparam logic [1:0] CMD_STOP = 2'h1;
   localparam logic [1:0] CMD_WAIT = 2'h2;
   // Clock dividers
   localparam int DIV_FAST = 2;
   localparam int DIV_SLOW = 32;
   // Oscillator settle count in internal cycles
   localparam int OSC_SETTLE_CYC = 4064;
   // Vectors
   localparam logic [15:0] SELFCHK_START = 16'h1f00;
   localparam logic [15:0] SELFCHK_END   = 16'h1fef;
   localparam logic [15:0] BOOT_START    = 16'h1000;
   localparam logic [15:0] BOOT_END      = 16'h1eff;
   localparam int          BOOT_BYTES    = 3840;
   // Self-check failure codes
   localparam logic [3:0] FAIL_PORTA = 4'hf;
   localparam logic [3:0] FAIL_PORTB = 4'he;
   localparam logic [3:0] FAIL_PORTC = 4'hd;
   localparam logic [3:0] FAIL_PORTD = 4'hc;
   localparam logic [3:0] FAIL_RAM   = 4'hb;
   localparam logic [3:0] FAIL_ROM   = 4'ha;
   localparam logic [3:0] FAIL_SWI   = 4'h8;
   localparam logic [3:0] FAIL_IRQ   = 4'h7;
   // Power states
   typedef enum logic [1:0] {
      LPBM_RUN    = 2'b00,
      LPBM_WAIT   = 2'b01,
      LPBM_STOP   = 2'b11,
      LPBM_SETTLE = 2'b10
   } lpbm_state_t;
endpackage : lpbm_pkg

/* File: design/lpbm_ctrl.sv */
// Purpose: Power-mode and boot-mode controller behind an APB slave.
// Assumes: CPU requests stop/wait by pulse or by register command.
// Notes:   Pins pass a two-stage synchroniser before use.
// Contract
// - Stop turns off the oscillator, halting all processing until wake.
// - Entering stop clears the CPU interrupt mask bit.
// - Stop keeps registers, memory and pin states unchanged.
// - Only a hardware interrupt or external reset ends stop.
// - Leaving stop waits a fixed count of cycles for oscillator settle.
// - Wait halts the CPU clock, other clocks including timer keep running.
// - Wait clears the CPU interrupt mask bit.
// - Timer interrupts can still wake from wait.
// - Slow select set gives bus clock oscillator divided by 32.
// - Slow select clear gives bus clock oscillator divided by 2.
// - Slow select is cleared on stop entry.
// - Low-voltage reset enable bit turns the function on or off.
// - Normal pin levels at reset release give user mode.
// - Test level and mode pin high at release give self-check mode.
// - After latching, the mode pin is free for ordinary use.
// - Self-check branches to the test program at 0x1f00 to 0x1fef.
// - Passing self-check flashes LEDs; failure shows a static code.
// - Failure codes on four LEDs per unit as listed.
// - Bootstrap runs the programmer for 0x1000 to 0x1eff, 3840 bytes.
//
// Decided for this implementation: the APB register port.
`timescale 1ns/10ps
module lpbm_ctrl #(
   parameter int SETTLE_CYC = lpbm_pkg::OSC_SETTLE_CYC,
   parameter int FLASH_CYC  = 25000000
) (
   // Clock and reset
   input  wire logic        MCLK_I,
   input  wire logic        RST_I,
   // APB slave
   input  wire logic        PSEL_I,
   input  wire logic        PENABLE_I,
   input  wire logic        PWRITE_I,
   input  wire logic [7:0]  PADDR_I,
   input  wire logic [31:0] PWDATA_I,
   output logic      [31:0] PRDATA_O,
   output logic             PREADY_O,
   output logic             PSLVERR_O,
   // CPU side
   input  wire logic        STOP_REQ_I,
   input  wire logic        WAIT_REQ_I,
   output logic             CLR_IMASK_O,
   output logic             TAKE_IRQ_O,
   output logic [15:0]      BOOT_VECTOR_O,
   output logic             SELF_CHECK_O,
   // Wake sources and pins
   input  wire logic        EXT_IRQ_I,
   input  wire logic        SECOND_EXT_INTERRUPT_I,
   input  wire logic        KEYPAD_WAKE_INTERRUPT_I,
   input  wire logic        TIMER_IRQ_I,
   input  wire logic        TEST_VOLTAGE_LEVEL_I,
   input  wire logic        MODE_SELECT_PIN_I,
   // Clock controls and status
   output logic             OSC_EN_O,
   output logic             CPU_CLK_EN_O,
   output logic             TIMER_CLK_EN_O,
   output logic             BUS_CLK_TICK_O,
   output logic             HOLD_IO_O,
   output logic             LVR_EN_O,
   output logic             MODE_PIN_FREE_O,
   output logic [3:0]       LED_O
);
   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers: two flops per pin, only the second one is read
   localparam int NPIN = 6;
   wire [NPIN-1:0] pin_raw = {MODE_SELECT_PIN_I, TEST_VOLTAGE_LEVEL_I,
                              TIMER_IRQ_I, KEYPAD_WAKE_INTERRUPT_I,
                              SECOND_EXT_INTERRUPT_I, EXT_IRQ_I};
   wire [NPIN-1:0] pin_sync;
   for (genvar g = 0; g < NPIN; g++) begin : g_sync
      logic [1:0] stage;
      always_ff @(posedge MCLK_I) begin
         stage <= {stage[0], pin_raw[g]};
      end
      assign pin_sync[g] = stage[1];
   end
   // Hardware interrupts end stop and wait; the timer ends wait only
   wire hw_irq   = pin_sync[0] | pin_sync[1] | pin_sync[2];
   wire any_wake = hw_irq | pin_sync[3];
   wire test_lvl = pin_sync[4];
   wire mode_pin = pin_sync[5];

   ////////////////////////////////////////////////////////////////////////
   // APB decode
   wire acc      = PSEL_I & PENABLE_I;
   wire wr       = acc & PWRITE_I;
   wire hit_misc = PADDR_I == lpbm_pkg::MISC_CTRL_OFF;
   wire hit_stat = PADDR_I == lpbm_pkg::MODE_STAT_OFF;
   wire hit_cmd  = PADDR_I == lpbm_pkg::PWR_CMD_OFF;
   wire hit_st   = PADDR_I == lpbm_pkg::SELFTEST_OFF;
   wire mapped   = hit_misc | hit_stat | hit_cmd | hit_st;

   logic [7:0]              misc;
   logic [7:0]              next_misc;
   lpbm_pkg::lpbm_state_t   state;
   lpbm_pkg::lpbm_state_t   next_state;
   logic [12:0]             settle;
   logic                    mode_latched;
   logic                    self_chk;
   logic                    fail_valid;
   logic [3:0]              fail_code;
   logic [24:0]             flash_cnt;
   logic                    flash;
   logic [4:0]              div_cnt;

   wire cmd_stop  = (wr & hit_cmd & PWDATA_I[1:0] == lpbm_pkg::CMD_STOP)
                    | STOP_REQ_I;
   wire cmd_wait  = (wr & hit_cmd & PWDATA_I[1:0] == lpbm_pkg::CMD_WAIT)
                    | WAIT_REQ_I;
   wire go_stop   = state == lpbm_pkg::LPBM_RUN & cmd_stop;
   wire go_wait   = state == lpbm_pkg::LPBM_RUN & ~cmd_stop & cmd_wait;

   ////////////////////////////////////////////////////////////////////////
   // Power state machine
   always_comb begin
      next_state = state;
      case (state)
         lpbm_pkg::LPBM_RUN: begin
            if (go_stop) begin
               next_state = lpbm_pkg::LPBM_STOP;
            end else if (go_wait) begin
               next_state = lpbm_pkg::LPBM_WAIT;
            end
         end
         lpbm_pkg::LPBM_WAIT: begin
            if (any_wake) begin
               next_state = lpbm_pkg::LPBM_RUN;
            end
         end
         lpbm_pkg::LPBM_STOP: begin
            if (hw_irq) begin
               next_state = lpbm_pkg::LPBM_SETTLE;
            end
         end
         lpbm_pkg::LPBM_SETTLE: begin
            if (settle == 13'(SETTLE_CYC - 1)) begin
               next_state = lpbm_pkg::LPBM_RUN;
            end
         end
         default: next_state = lpbm_pkg::LPBM_RUN;
      endcase
   end

   always_ff @(posedge MCLK_I) begin
      if (RST_I) begin
         state  <= lpbm_pkg::LPBM_RUN;
         settle <= 13'h0;
      end else begin
         state  <= next_state;
         settle <= (state == lpbm_pkg::LPBM_SETTLE) ? settle + 13'h1
                                                   : 13'h0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Control register
   always_comb begin
      next_misc = misc;
      if (wr & hit_misc) begin
         next_misc = PWDATA_I[7:0];
      end
      if (go_stop) begin
         next_misc[lpbm_pkg::SM_BIT] = 1'b0;
      end
   end

   always_ff @(posedge MCLK_I) begin
      if (RST_I) begin
         misc <= lpbm_pkg::MISC_CTRL_RST;
      end else begin
         misc <= next_misc;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Bus clock divider: ticks once per divide period
   wire slow = misc[lpbm_pkg::SM_BIT];
   wire [4:0] div_top = slow ? 5'(lpbm_pkg::DIV_SLOW - 1)
                             : 5'(lpbm_pkg::DIV_FAST - 1);
   // Taken from the next state so no tick leaks into the first stopped
   // cycle and ticking resumes with the run state
   wire osc_run = next_state != lpbm_pkg::LPBM_STOP
                  & next_state != lpbm_pkg::LPBM_SETTLE;
   always_ff @(posedge MCLK_I) begin
      if (RST_I) begin
         div_cnt        <= 5'h0;
         BUS_CLK_TICK_O <= 1'b0;
      end else if (!osc_run) begin
         div_cnt        <= 5'h0;
         BUS_CLK_TICK_O <= 1'b0;
      end else begin
         div_cnt        <= (div_cnt >= div_top) ? 5'h0 : div_cnt + 5'h1;
         BUS_CLK_TICK_O <= div_cnt >= div_top;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Mode latch at reset release
   always_ff @(posedge MCLK_I) begin
      if (RST_I) begin
         mode_latched <= 1'b0;
         self_chk     <= 1'b0;
      end else if (!mode_latched) begin
         mode_latched <= 1'b1;
         self_chk     <= test_lvl & mode_pin;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Self-check report
   always_ff @(posedge MCLK_I) begin
      if (RST_I) begin
         fail_valid <= 1'b0;
         fail_code  <= 4'h0;
         flash_cnt  <= 25'h0;
         flash      <= 1'b0;
      end else begin
         if (wr & hit_st & self_chk & !fail_valid) begin
            fail_valid <= PWDATA_I[4];
            fail_code  <= PWDATA_I[3:0];
         end
         if (flash_cnt == 25'(FLASH_CYC - 1)) begin
            flash_cnt <= 25'h0;
            flash     <= ~flash;
         end else begin
            flash_cnt <= flash_cnt + 25'h1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Registered outputs
   wire [31:0] rd_data =
      hit_misc ? {24'h0, misc} :
      hit_stat ? {26'h0, fail_valid, self_chk, mode_latched, 1'b0, state} :
      hit_st   ? {27'h0, fail_valid, fail_code} : 32'h0;

   always_ff @(posedge MCLK_I) begin
      if (RST_I) begin
         PRDATA_O        <= 32'h0;
         PREADY_O        <= 1'b0;
         PSLVERR_O       <= 1'b0;
         CLR_IMASK_O     <= 1'b0;
         TAKE_IRQ_O      <= 1'b0;
         BOOT_VECTOR_O   <= lpbm_pkg::BOOT_START;
         SELF_CHECK_O    <= 1'b0;
         OSC_EN_O        <= 1'b1;
         CPU_CLK_EN_O    <= 1'b1;
         TIMER_CLK_EN_O  <= 1'b1;
         HOLD_IO_O       <= 1'b0;
         LVR_EN_O        <= 1'b0;
         MODE_PIN_FREE_O <= 1'b0;
         LED_O           <= 4'h0;
      end else begin
         PREADY_O    <= PSEL_I & ~PENABLE_I;
         PRDATA_O    <= (PSEL_I & ~PENABLE_I & ~PWRITE_I) ? rd_data : 32'h0;
         PSLVERR_O   <= PSEL_I & ~PENABLE_I & ~mapped;
         CLR_IMASK_O <= go_stop | go_wait;
         TAKE_IRQ_O  <= (state == lpbm_pkg::LPBM_WAIT & any_wake)
                        | (state == lpbm_pkg::LPBM_SETTLE
                           & next_state == lpbm_pkg::LPBM_RUN);
         BOOT_VECTOR_O <= self_chk ? lpbm_pkg::SELFCHK_START
                                   : lpbm_pkg::BOOT_START;
         SELF_CHECK_O  <= self_chk;
         OSC_EN_O      <= next_state != lpbm_pkg::LPBM_STOP;
         CPU_CLK_EN_O  <= next_state == lpbm_pkg::LPBM_RUN;
         TIMER_CLK_EN_O <= next_state == lpbm_pkg::LPBM_RUN
                           | next_state == lpbm_pkg::LPBM_WAIT;
         HOLD_IO_O     <= next_state != lpbm_pkg::LPBM_RUN;
         LVR_EN_O      <= next_misc[lpbm_pkg::LOW_VOLTAGE_RESET_ENABLE_BIT];
         MODE_PIN_FREE_O <= mode_latched;
         LED_O <= !self_chk ? 4'h0 :
                  fail_valid ? fail_code : {4{flash}};
      end
   end
endmodule : lpbm_ctrl

/* File: dv/lpbm_ctrl_properties.sv */
// Purpose: Port checks for the low-power and boot-mode controller.
// Assumes: One clock, reset synchronous and active high.
// Notes:   Settle length follows the bound instance.
`timescale 1ns/10ps
module lpbm_ctrl_chk #(parameter int SETTLE_CYC = 4) (
   input wire logic        MCLK_I, RST_I, PSEL_I, PENABLE_I, PWRITE_I,
   input wire logic [7:0]  PADDR_I,
   input wire logic [31:0] PWDATA_I,
   input wire logic        PREADY_O, STOP_REQ_I, WAIT_REQ_I, CLR_IMASK_O,
   input wire logic        TAKE_IRQ_O, SELF_CHECK_O, MODE_PIN_FREE_O,
   input wire logic [15:0] BOOT_VECTOR_O,
   input wire logic        EXT_IRQ_I, SECOND_EXT_INTERRUPT_I,
   input wire logic        KEYPAD_WAKE_INTERRUPT_I, TIMER_IRQ_I,
   input wire logic        TEST_VOLTAGE_LEVEL_I, MODE_SELECT_PIN_I,
   input wire logic        OSC_EN_O, CPU_CLK_EN_O, TIMER_CLK_EN_O,
   input wire logic        BUS_CLK_TICK_O, HOLD_IO_O, LVR_EN_O,
   input wire logic [3:0]  LED_O
);
   default clocking cb @(posedge MCLK_I); endclocking
   default disable iff (RST_I);
   wire logic wake = EXT_IRQ_I | SECOND_EXT_INTERRUPT_I
                   | KEYPAD_WAKE_INTERRUPT_I;
   wire logic settle = OSC_EN_O & ~TIMER_CLK_EN_O;
   int        cnt;
   // Cycles with the oscillator back but the CPU still held
   always_ff @(posedge MCLK_I)
      cnt <= (RST_I || !settle) ? 0 : cnt + 1;
   property p_lvr;
      logic v;
      (PSEL_I && PENABLE_I && PWRITE_I && PREADY_O && PADDR_I == 8'h0c,
       v = PWDATA_I[3]) |=> LVR_EN_O == v;
   endproperty
   ////////////////////////////////////////////////////////////////////////
   a_stop_osc_off: assert property (
      STOP_REQ_I && CPU_CLK_EN_O |=> !OSC_EN_O && HOLD_IO_O)
      else $error("oscillator not off after stop");
   a_entry_mask: assert property (
      (STOP_REQ_I || WAIT_REQ_I) && CPU_CLK_EN_O
      |=> CLR_IMASK_O ##1 !CLR_IMASK_O)
      else $error("mask clear pulse missing");
   a_stop_frozen: assert property (
      !OSC_EN_O |-> HOLD_IO_O && !CPU_CLK_EN_O && !BUS_CLK_TICK_O
                    && $stable(LVR_EN_O))
      else $error("activity while stopped");
   a_only_irq_wakes: assert property (
      !OSC_EN_O && !wake && !$past(wake) && !$past(wake, 2) |=> !OSC_EN_O)
      else $error("stop left without wake source");
   a_settle_len: assert property (
      $rose(CPU_CLK_EN_O) && cnt != 0 |-> cnt == SETTLE_CYC && TAKE_IRQ_O)
      else $error("settle length wrong");
   a_wait_clocks: assert property (
      TIMER_CLK_EN_O && !CPU_CLK_EN_O |-> OSC_EN_O && HOLD_IO_O)
      else $error("wait clocks wrong");
   a_timer_wake: assert property (
      (TIMER_CLK_EN_O && !CPU_CLK_EN_O && TIMER_IRQ_I)[*3]
      |-> ##[0:4] CPU_CLK_EN_O)
      else $error("timer did not end wait");
   a_tick_pulse: assert property (
      BUS_CLK_TICK_O |=> !BUS_CLK_TICK_O)
      else $error("bus tick too long");
   a_lvr_write: assert property (p_lvr)
      else $error("lvr enable does not follow write");
   // Pins count as seen before release; outputs settle two edges later
   a_user_boot: assert property (
      $fell(RST_I) && !($past(TEST_VOLTAGE_LEVEL_I, 2)
                        && $past(MODE_SELECT_PIN_I, 2))
      |-> ##2 !SELF_CHECK_O && BOOT_VECTOR_O == 16'h1000 && MODE_PIN_FREE_O)
      else $error("user mode not selected");
   a_self_boot: assert property (
      $fell(RST_I) && $past(TEST_VOLTAGE_LEVEL_I, 2)
      && $past(MODE_SELECT_PIN_I, 2)
      |-> ##2 SELF_CHECK_O && BOOT_VECTOR_O == 16'h1f00 && MODE_PIN_FREE_O)
      else $error("self-check not selected");
   a_led_quiet: assert property (
      !SELF_CHECK_O |-> LED_O == 4'h0)
      else $error("leds lit outside self-check");
   cover property (!OSC_EN_O);
   cover property (TIMER_CLK_EN_O && !CPU_CLK_EN_O);
   cover property (SELF_CHECK_O && LED_O != 4'h0);
   cover property ($rose(CPU_CLK_EN_O) && TAKE_IRQ_O);
endmodule : lpbm_ctrl_chk
bind lpbm_ctrl lpbm_ctrl_chk #(.SETTLE_CYC(SETTLE_CYC)) u_chk (.*);

/* File: dv/lpbm_pins_model.sv */
// Purpose: Board side: wake sources and mode pins.
// Assumes: Levels requested by the bench.
// Notes:   Mode pin is reused by the board after reset.
`timescale 1ns/10ps
module lpbm_pins_model (
   input wire logic       clk_i, rst_i, selfchk_i,
   input wire logic [3:0] wake_i,
   output logic           ext_o, sec_o, kbd_o, tmr_o, test_o, mode_o
);
   logic tog;
   // Wake levels: external, second, keypad, timer
   assign {tmr_o, kbd_o, sec_o, ext_o} = wake_i;
   assign test_o = selfchk_i;
   // Once latched the pin carries unrelated traffic
   always_ff @(posedge clk_i)
      tog <= rst_i ? 1'b0 : ~tog;
   assign mode_o = rst_i ? selfchk_i : tog;
endmodule : lpbm_pins_model

/* File: dv/lpbm_ctrl_tb_top.sv */
// Purpose: Self-checking bench for the low-power and boot-mode controller.
// Assumes: Short settle and flash counts.
// Notes:   Read results checked from a queue by a monitor.
`timescale 1ns/10ps
module lpbm_ctrl_tb_top;
   logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, stp = 0, wtr = 0;
   logic sc = 0, pready, pslverr, self_chk, osc_en, cpu_en, tmr_en, tick;
   logic hold_io, lvr_en, ext, sec, kbd, tmr, tst, mode;
   logic clr_im, take_irq, pin_free;
   int n_clr = 0, n_take = 0;
   logic [7:0] pa = 0;
   logic [31:0] pwd = 0, prdata, r;
   logic [15:0] boot_vec;
   logic [3:0] wk = 0, led, l0;
   logic [32:0] expq[$];
   int n_fail = 0, comparisons = 0, cyc = 0, cnt;
   localparam logic [31:0] CODES = 32'hfedcba87;
   always #10 clk = ~clk;
   lpbm_ctrl #(.SETTLE_CYC(4), .FLASH_CYC(8)) dut (.MCLK_I(clk),
      .RST_I(rst), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
      .PADDR_I(pa), .PWDATA_I(pwd), .PRDATA_O(prdata), .PREADY_O(pready),
      .PSLVERR_O(pslverr), .STOP_REQ_I(stp), .WAIT_REQ_I(wtr),
      .CLR_IMASK_O(clr_im), .TAKE_IRQ_O(take_irq), .BOOT_VECTOR_O(boot_vec),
      .SELF_CHECK_O(self_chk), .EXT_IRQ_I(ext), .SECOND_EXT_INTERRUPT_I(sec),
      .KEYPAD_WAKE_INTERRUPT_I(kbd), .TIMER_IRQ_I(tmr),
      .TEST_VOLTAGE_LEVEL_I(tst), .MODE_SELECT_PIN_I(mode),
      .OSC_EN_O(osc_en), .CPU_CLK_EN_O(cpu_en), .TIMER_CLK_EN_O(tmr_en),
      .BUS_CLK_TICK_O(tick), .HOLD_IO_O(hold_io), .LVR_EN_O(lvr_en),
      .MODE_PIN_FREE_O(pin_free), .LED_O(led));
   lpbm_pins_model u_pins (.clk_i(clk), .rst_i(rst), .selfchk_i(sc),
      .wake_i(wk), .ext_o(ext), .sec_o(sec), .kbd_o(kbd), .tmr_o(tmr),
      .test_o(tst), .mode_o(mode));
   ////////////////////////////////////////////////////////////////////////
   task automatic final_report;
      if (n_fail == 0 && comparisons > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : final_report
   task automatic chk(input logic [32:0] got, input logic [32:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      psel <= 1;
      pwr <= w;
      pa <= a;
      pwd <= d;
      @(posedge clk) pen <= 1;
      do @(posedge clk); while (pready !== 1'b1);
      psel <= 0;
      pen <= 0;
      @(posedge clk);
   endtask : apb
   task automatic rd(input logic [7:0] a, input logic [32:0] e);
      expq.push_back(e);
      apb(0, a, 32'h0);
   endtask : rd
   task automatic do_reset(input logic s);
      sc <= s;
      rst <= 1;
      repeat (10) @(posedge clk);
      rst <= 0;
      repeat (3) @(posedge clk);
   endtask : do_reset
   task automatic pulse(input logic s);
      if (s) stp <= 1;
      else wtr <= 1;
      @(posedge clk);
      stp <= 0;
      wtr <= 0;
      @(posedge clk);
   endtask : pulse
   task automatic wake(input int i);
      wk <= 4'h1 << i;
      cnt = 0;
      while (cpu_en !== 1'b1 && cnt < 100) begin
         @(posedge clk);
         cnt++;
      end
      wk <= 0;
      repeat (4) @(posedge clk);
   endtask : wake
   ////////////////////////////////////////////////////////////////////////
   always @(posedge clk) begin
      if (psel && pen && !pwr && pready === 1'b1 && expq.size() > 0)
         chk({pslverr, prdata}, expq.pop_front());
   end
   // Counts of mask-clear and take-interrupt pulses
   always @(posedge clk) begin
      n_clr += (clr_im === 1'b1);
      n_take += (take_irq === 1'b1);
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         n_fail++;
         final_report;
      end
   end
   initial begin
      void'($urandom(32'he518));
      do_reset(0);
      chk({self_chk, boot_vec}, {1'b0, 16'h1000});
      chk(pin_free, 1);
      rd(8'h10, 33'h8);
      rd(8'h0c, 33'h10);
      rd(8'h40, 33'h1_0000_0000);
      r = $urandom;
      apb(1, 8'h0c, r);
      rd(8'h0c, {25'h0, r[7:0]});
      chk(lvr_en, r[3]);
      for (int m = 0; m < 2; m++) begin
         apb(1, 8'h0c, {29'h0, m == 0, 2'h0});
         repeat (4) @(posedge clk);
         cnt = 0;
         repeat (64) @(posedge clk) cnt += tick;
         chk(cnt, m ? 32 : 2);
      end
      for (int s = 0; s < 3; s++) begin
         apb(1, 8'h0c, 32'h4);
         if (s == 2) apb(1, 8'h14, 32'h1);
         else pulse(1);
         wk <= 4'h8;
         repeat (6) @(posedge clk);
         chk({osc_en, hold_io}, 2'b01);
         wake(s);
         chk(cpu_en, 1);
         rd(8'h0c, 33'h0);
      end
      chk(n_clr, 3);
      chk(n_take, 3);
      for (int w = 0; w < 2; w++) begin
         if (w) apb(1, 8'h14, 32'h2);
         else pulse(0);
         repeat (3) @(posedge clk);
         chk({osc_en, tmr_en, cpu_en}, 3'b110);
         wake(3);
         chk(cpu_en, 1);
      end
      chk(n_clr, 5);
      chk(n_take, 5);
      for (int i = 0; i < 8; i++) begin
         do_reset(1);
         chk({self_chk, boot_vec}, {1'b1, 16'h1f00});
         chk(pin_free, 1);
         l0 = led;
         repeat (8) @(posedge clk);
         chk(led !== l0, 1);
         apb(1, 8'h18, {27'h0, 1'b1, CODES[4*i +: 4]});
         repeat (2) @(posedge clk);
         chk(led, CODES[4*i +: 4]);
         rd(8'h18, {29'h1, CODES[4*i +: 4]});
         rd(8'h10, 33'h38);
      end
      final_report;
   end
endmodule : lpbm_ctrl_tb_top
